// [verilog/vc12d_pkg.sv]
// Constants and types shared by the VC-12 asynchronous 2 Mbit/s sink
package vc12d_pkg;

  //--------------------------------------------------------------------
  // Clocking and smoothing
  //--------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int TRIB_HZ = 2_048_000;
  // Phase step per MCLK cycle of the 2 048 kHz output oscillator
  localparam logic [31:0] NCO_NOM = 32'((64'(TRIB_HZ) << 32) / 64'(CLK_HZ));
  localparam int ES_DEPTH = 64;
  localparam int ES_TRIM_SHIFT = 8;

  //--------------------------------------------------------------------
  // Container layout and signal label
  //--------------------------------------------------------------------
  localparam logic [10:0] CONT_BITS = 11'd1120;
  localparam logic [7:0] SUB_BYTES = 8'd35;
  localparam logic [7:0] SUB_LAST = 8'd34;
  localparam logic [2:0] LABEL_FIRST_BIT = 3'h4;
  localparam logic [2:0] LABEL_LAST_BIT = 3'h6;
  localparam logic [1:0] FRAME_S = 2'h3;
  localparam logic [2:0] LABEL_ASYNC = 3'h2;
  localparam logic [2:0] LABEL_ACCEPT_RUN = 3'h4;

  //--------------------------------------------------------------------
  // 2 Mbit/s framing and all-ones detection
  //--------------------------------------------------------------------
  localparam logic [7:0] TS0_LAST = 8'h07;
  localparam logic [7:0] FRAME_LAST = 8'hFF;
  localparam logic [6:0] FAS_WORD = 7'h1B;
  localparam logic [5:0] MFAS_WORD = 6'h0B;
  localparam logic [3:0] MF_LAST_NFAS = 4'hB;
  localparam logic [1:0] LOF_ERRORS = 2'h3;
  localparam int MFA_SEARCH_MS = 400;
  localparam int MFA_SEARCH_CYC = MFA_SEARCH_MS * (CLK_HZ / 1000);
  localparam logic [1:0] AIS_X = 2'h2;
  localparam logic [8:0] AIS_Y_LAST = 9'h1FF;
  localparam logic [1:0] AIS_Z = 2'h3;

  //--------------------------------------------------------------------
  // Register map
  //--------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  typedef enum logic [1:0] {
    CRC_OFF = 2'b00,
    CRC_ON = 2'b01,
    CRC_AUTO = 2'b10
  } vc12d_crc_mode_t;

  typedef enum logic [2:0] {
    BK_IGN = 3'b000,
    BK_DATA = 3'b001,
    BK_C1 = 3'b010,
    BK_C2 = 3'b011,
    BK_S1 = 3'b100,
    BK_S2 = 3'b101,
    BK_LABEL = 3'b110
  } vc12d_bit_kind_t;

  typedef enum logic [2:0] {
    FA_OUT = 3'b000,
    FA_CHK_NFAS = 3'b001,
    FA_CHK_FAS = 3'b010,
    FA_IN_BFA = 3'b011,
    FA_MF_SEARCH = 3'b100,
    FA_CRC_CRC = 3'b101,
    FA_CRC_NONCRC = 3'b110
  } vc12d_fa_state_t;

  typedef struct packed {
    vc12d_crc_mode_t crc_multiframe_setting;
    logic all_ones_report_enable;
    logic activation_control;
  } vc12d_ctrl_t;

  localparam vc12d_ctrl_t CTRL_RESET = 4'hB;

  typedef struct packed {
    logic loss_of_frame_defect;
    logic incoming_all_ones_defect;
    logic payload_mismatch_defect;
    logic multiframe_present;
    logic no_crc_interworking_status;
    logic [2:0] accepted_signal_label;
    logic frame_loss_cause;
    logic all_ones_cause;
    logic payload_mismatch_cause;
  } vc12d_status_t;

endpackage : vc12d_pkg

// [verilog/vc12d_elastic_store.sv]
// Bit-wide elastic store between the gapped and the smoothed clock
module vc12d_elastic_store #(
  parameter int DEPTH = 64,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic wr_bit,
  input wire logic rd_en,
  output logic rd_bit,
  output logic [AW:0] fill
);

  logic [DEPTH-1:0] mem;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic slip;

  // A full write or an empty read is a slip; recentring bounds the
  // damage after a frequency step to one burst of errors
  assign slip = (wr_en && !rd_en && fill == (AW+1)'(DEPTH))
    || (rd_en && !wr_en && fill == '0);

  // Storage cells
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_ptr] <= wr_bit;
  end

  // Pointers and fill level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= AW'(DEPTH / 2);
      rd_ptr <= '0;
      fill <= (AW+1)'(DEPTH / 2);
      rd_bit <= 1'b1;
    end
    else if (slip)
    begin
      rd_ptr <= wr_ptr - AW'(DEPTH / 2);
      fill <= (AW+1)'(DEPTH / 2);
    end
    else
    begin
      if (wr_en)
        wr_ptr <= wr_ptr + 1'b1;
      if (rd_en)
      begin
        rd_ptr <= rd_ptr + 1'b1;
        rd_bit <= mem[rd_ptr];
      end
      if (wr_en && !rd_en)
        fill <= fill + 1'b1;
      else if (rd_en && !wr_en)
        fill <= fill - 1'b1;
    end
  end

endmodule : vc12d_elastic_store

// [verilog/vc12d_sink.sv]
// VC-12 asynchronous 2 Mbit/s demapping sink with APB management
//----------------------------------------------------------------------
// Notes on behaviour
// - Accepted label bits 5 to 7 other than 010 raise payload mismatch.
// - Fixed stuff and overhead bits never reach the payload.
// - First opportunity bit is data on C1 majority 0, dropped on 1.
// - Second opportunity bit is data on C2 majority 0, dropped on 1.
// - Payload written on gapped clock, read on smoothed 2 048 kHz.
// - Store deep enough for 50 ppm offset plus specified jitter.
// - After a frequency step smoothing recovers error-free within bound.
// - Frame and multiframe phase found from accepted payload bits.
// - Manual and automatic CRC-4 interworking both supported.
// - Multiframe present stays false with CRC-4 setting OFF.
// - With ON, multiframe present is true once multiframe found.
// - With AUTO, multiframe present true only in CRC-to-CRC state.
// - Inactive: all-ones data out and no status reported.
// - Loss of frame declared and cleared by frame word checks.
// - AUTO mode reports no-CRC interworking when far end lacks CRC-4.
// - All-ones defect: X 2, Y 512 to set, Z 3 to clear.
// - Server fail and all-ones insertion follow any of three defects.
// - Data switches to and from all-ones within 500 us.
// - Mismatch cause needs mismatch defect without trail fail.
// - All-ones cause needs defect, no mismatch, no trail fail, enable.
// - Frame loss cause needs loss, no all-ones, mismatch or trail fail.
//----------------------------------------------------------------------
module vc12d_sink #(
  parameter int ES_DEPTH = vc12d_pkg::ES_DEPTH,
  parameter int MFA_TIMEOUT_CYC = vc12d_pkg::MFA_SEARCH_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CONTAINER_DATA_IN,
  input wire logic CONTAINER_GAPPED_CLOCK_IN,
  input wire logic CONTAINER_FRAME_START_IN,
  input wire logic TRAIL_SIGNAL_FAIL_IN,
  output logic TRIBUTARY_DATA_OUT,
  output logic TRIBUTARY_CLOCK_OUT,
  output logic SERVER_FAIL_OUT,
  output logic FRAME_START_OUT,
  output logic MULTIFRAME_START_OUT,
  output logic MULTIFRAME_PRESENT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  import vc12d_pkg::*;

  localparam int AW = $clog2(ES_DEPTH);
  localparam int TW = $clog2(MFA_TIMEOUT_CYC + 1);

  //--------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------
  logic ck_s1, ck_s2, ck_s3;
  logic d_s1, d_s2, fs_s1, fs_s2, tsf_s1, tsf_s2;
  logic in_edge, framed, bit_ok, wr_en;
  logic [10:0] idx;
  logic [10:0] cur_idx;
  vc12d_bit_kind_t kind;
  logic [1:0] c1_cnt, c2_cnt;
  logic [1:0] lab_sh;
  logic [2:0] lab_new, lab_cand, lab_run, accepted;
  logic [AW:0] fill;
  logic [31:0] acc, nco_inc;
  logic [32:0] nco_sum;
  logic rd_en, rd_d, ob;
  logic [7:0] sh, ts0, pos;
  logic fas_hit, fpar;
  logic [1:0] fas_err;
  logic [4:0] mf_sh;
  logic [3:0] mfc;
  vc12d_fa_state_t fa_state;
  logic [TW-1:0] tmr;
  logic mfa_timeout;
  logic [8:0] ais_win;
  logic [1:0] ais_zeros, ais_zt;
  logic plm_d, ais_d, lof_d, ssf;
  vc12d_ctrl_t ctrl;
  vc12d_status_t status;
  logic apb_setup, apb_wr, addr_ok;

  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  // Role of one container bit, from its position counted from the label byte
  function automatic vc12d_bit_kind_t classify(input logic [10:0] i);
    logic [7:0] byte_n;
    logic [7:0] p;
    logic [7:0] f;
    logic [2:0] b;
    byte_n = i[10:3];
    b = i[2:0];
    p = byte_n % SUB_BYTES;
    f = byte_n / SUB_BYTES;
    classify = BK_DATA;
    if (p == 8'h00)
      classify = (f == 8'h00 && b >= LABEL_FIRST_BIT && b <= LABEL_LAST_BIT)
        ? BK_LABEL : BK_IGN;
    else if (p == 8'h01)
    begin
      if (f == 8'h00)
        classify = BK_IGN;
      else if (b == 3'h0)
        classify = BK_C1;
      else if (b == 3'h1)
        classify = BK_C2;
      else if (f[1:0] == FRAME_S && b == 3'h7)
        classify = BK_S1;
      else
        classify = BK_IGN;
    end
    else if (p == 8'h02 && f[1:0] == FRAME_S && b == 3'h0)
      classify = BK_S2;
    else if (p == SUB_LAST)
      classify = BK_IGN;
  endfunction : classify

  // Majority of three control bits, given the count of ones
  function automatic logic majority(input logic [1:0] ones);
    majority = ones >= 2'h2;
  endfunction : majority

  //--------------------------------------------------------------------
  // Container input
  //--------------------------------------------------------------------
  // Two-stage synchronisers; the third clock stage only finds edges
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      {ck_s1, ck_s2, ck_s3} <= 3'h0;
      {d_s1, d_s2, fs_s1, fs_s2} <= 4'h0;
      {tsf_s1, tsf_s2} <= 2'h0;
    end
    else
    begin
      ck_s1 <= CONTAINER_GAPPED_CLOCK_IN;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      d_s1 <= CONTAINER_DATA_IN;
      d_s2 <= d_s1;
      fs_s1 <= CONTAINER_FRAME_START_IN;
      fs_s2 <= fs_s1;
      tsf_s1 <= TRAIL_SIGNAL_FAIL_IN;
      tsf_s2 <= tsf_s1;
    end
  end

  assign in_edge = ck_s2 && !ck_s3;
  assign cur_idx = fs_s2 ? 11'h000 : idx;
  assign kind = classify(cur_idx);
  assign bit_ok = in_edge && (framed || fs_s2);

  // Bit position in the 500 us container, restarted by frame start
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      idx <= 11'h000;
      framed <= 1'b0;
    end
    else if (in_edge)
    begin
      framed <= framed || fs_s2;
      idx <= (cur_idx == CONT_BITS - 11'h001) ? 11'h000 : cur_idx + 11'h001;
    end
  end

  // Ones among the control bits of the current container
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      c1_cnt <= 2'h0;
      c2_cnt <= 2'h0;
    end
    else if (bit_ok)
    begin
      if (fs_s2)
      begin
        c1_cnt <= 2'h0;
        c2_cnt <= 2'h0;
      end
      else if (kind == BK_C1 && d_s2)
        c1_cnt <= c1_cnt + 2'h1;
      else if (kind == BK_C2 && d_s2)
        c2_cnt <= c2_cnt + 2'h1;
    end
  end

  // Only data bits and accepted opportunity bits enter the store
  assign wr_en = bit_ok && (kind == BK_DATA
    || (kind == BK_S1 && !majority(c1_cnt))
    || (kind == BK_S2 && !majority(c2_cnt)));

  // Label acceptance: the same code in six containers running
  assign lab_new = {lab_sh, d_s2};
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      lab_sh <= 2'h0;
      lab_cand <= 3'h0;
      lab_run <= 3'h0;
      accepted <= 3'h0;
    end
    else if (bit_ok && kind == BK_LABEL)
    begin
      lab_sh <= lab_new[1:0];
      if (cur_idx[2:0] == LABEL_LAST_BIT)
      begin
        if (lab_new != lab_cand)
        begin
          lab_cand <= lab_new;
          lab_run <= 3'h0;
        end
        else if (lab_run != LABEL_ACCEPT_RUN)
          lab_run <= lab_run + 3'h1;
        else
          accepted <= lab_cand;
      end
    end
  end

  assign plm_d = accepted != LABEL_ASYNC;

  //--------------------------------------------------------------------
  // Smoothing
  //--------------------------------------------------------------------
  // The fill offset trims the oscillator so the read rate follows the
  // far-end rate; the trim range exceeds 50 ppm on purpose
  assign nco_inc = NCO_NOM + (32'(fill) << ES_TRIM_SHIFT)
    - (32'(ES_DEPTH / 2) << ES_TRIM_SHIFT);
  assign nco_sum = {1'b0, acc} + {1'b0, nco_inc};
  assign rd_en = nco_sum[32];

  // Oscillator phase and read strobe delay
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      acc <= 32'h0000_0000;
      rd_d <= 1'b0;
    end
    else
    begin
      acc <= nco_sum[31:0];
      rd_d <= rd_en;
    end
  end

  // Depth covers bursts of a subframe plus pointer jitter
  vc12d_elastic_store #(
    .DEPTH(ES_DEPTH)
  ) u_store (
    .clk(MCLK),
    .rst(RST),
    .wr_en(wr_en),
    .wr_bit(d_s2),
    .rd_en(rd_en),
    .rd_bit(ob),
    .fill(fill)
  );

  //--------------------------------------------------------------------
  // Frame and multiframe alignment on the smoothed stream
  //--------------------------------------------------------------------
  assign ts0 = {sh[6:0], ob};
  assign fas_hit = ts0[6:0] == FAS_WORD;
  assign lof_d = fa_state == FA_OUT || fa_state == FA_CHK_NFAS
    || fa_state == FA_CHK_FAS;

  // Alignment states; loss of frame is checked last so it always wins
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      fa_state <= FA_OUT;
      sh <= 8'h00;
      pos <= 8'h00;
      fpar <= 1'b0;
      fas_err <= 2'h0;
      mf_sh <= 5'h00;
      mfc <= 4'h0;
    end
    else if (rd_d)
    begin
      sh <= ts0;
      pos <= pos + 8'h01;
      if (pos == FRAME_LAST)
      begin
        fpar <= ~fpar;
        mfc <= mfc + 4'h1;
      end
      if (pos == TS0_LAST && fpar)
        mf_sh <= {mf_sh[3:0], ts0[7]};
      case (fa_state)
        FA_OUT:
        begin
          if (fas_hit)
          begin
            fa_state <= FA_CHK_NFAS;
            pos <= TS0_LAST + 8'h01;
            fpar <= 1'b0;
          end
        end
        FA_CHK_NFAS:
        begin
          if (pos == TS0_LAST)
            fa_state <= ts0[6] ? FA_CHK_FAS : FA_OUT;
        end
        FA_CHK_FAS:
        begin
          if (pos == TS0_LAST && !fas_hit)
            fa_state <= FA_OUT;
          else if (pos == TS0_LAST)
          begin
            fas_err <= 2'h0;
            fa_state <= (ctrl.crc_multiframe_setting == CRC_OFF)
              ? FA_IN_BFA : FA_MF_SEARCH;
          end
        end
        default:
        begin
          if (ctrl.crc_multiframe_setting == CRC_OFF)
            fa_state <= FA_IN_BFA;
          else if (fa_state == FA_IN_BFA)
            fa_state <= FA_MF_SEARCH;
          else if (fa_state == FA_MF_SEARCH && pos == TS0_LAST && fpar
            && {mf_sh, ts0[7]} == MFAS_WORD)
          begin
            fa_state <= FA_CRC_CRC;
            mfc <= MF_LAST_NFAS;
          end
          else if (fa_state == FA_MF_SEARCH && mfa_timeout)
            fa_state <= FA_CRC_NONCRC;
          else if (fa_state == FA_CRC_NONCRC
            && ctrl.crc_multiframe_setting != CRC_AUTO)
            fa_state <= FA_MF_SEARCH;
          if (pos == TS0_LAST && !fpar)
          begin
            if (fas_hit)
              fas_err <= 2'h0;
            else if (fas_err == LOF_ERRORS - 2'h1)
              fa_state <= FA_OUT;
            else
              fas_err <= fas_err + 2'h1;
          end
        end
      endcase
    end
  end

  // Search timer; only automatic interworking gives up on the far end
  always_ff @(posedge MCLK)
  begin
    if (RST || fa_state != FA_MF_SEARCH
      || ctrl.crc_multiframe_setting != CRC_AUTO)
      tmr <= '0;
    else if (!mfa_timeout)
      tmr <= tmr + 1'b1;
  end

  assign mfa_timeout = tmr == TW'(MFA_TIMEOUT_CYC);

  //--------------------------------------------------------------------
  // All-ones detection on the incoming smoothed stream
  //--------------------------------------------------------------------
  assign ais_zt = (ob || ais_zeros == 2'h3) ? ais_zeros : ais_zeros + 2'h1;

  // Zeros counted per 512-bit window; between X and Z the state holds
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ais_win <= 9'h000;
      ais_zeros <= 2'h0;
      ais_d <= 1'b0;
    end
    else if (rd_d)
    begin
      ais_win <= ais_win + 9'h001;
      if (ais_win == AIS_Y_LAST)
      begin
        ais_zeros <= 2'h0;
        if (ais_zt < AIS_X)
          ais_d <= 1'b1;
        else if (ais_zt >= AIS_Z)
          ais_d <= 1'b0;
      end
      else
        ais_zeros <= ais_zt;
    end
  end

  assign ssf = plm_d || ais_d || lof_d;

  //--------------------------------------------------------------------
  // Tributary outputs
  //--------------------------------------------------------------------
  // Insertion acts on the next output bit, far inside the allowed delay
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      TRIBUTARY_DATA_OUT <= 1'b1;
      TRIBUTARY_CLOCK_OUT <= 1'b0;
      SERVER_FAIL_OUT <= 1'b1;
      FRAME_START_OUT <= 1'b0;
      MULTIFRAME_START_OUT <= 1'b0;
      MULTIFRAME_PRESENT <= 1'b0;
    end
    else
    begin
      TRIBUTARY_CLOCK_OUT <= acc[31];
      SERVER_FAIL_OUT <= ssf;
      MULTIFRAME_PRESENT <= ctrl.crc_multiframe_setting != CRC_OFF
        && fa_state == FA_CRC_CRC;
      FRAME_START_OUT <= rd_d && !lof_d && pos == 8'h00;
      MULTIFRAME_START_OUT <= rd_d && pos == 8'h00
        && fa_state == FA_CRC_CRC && mfc == 4'h0;
      if (rd_d)
        TRIBUTARY_DATA_OUT <= (ssf || !ctrl.activation_control)
          ? 1'b1 : ob;
    end
  end

  //--------------------------------------------------------------------
  // Management
  //--------------------------------------------------------------------
  // Status image; all zero while the block is not activated
  always_comb
  begin
    status = '0;
    if (ctrl.activation_control)
    begin
      status.loss_of_frame_defect = lof_d;
      status.incoming_all_ones_defect = ais_d;
      status.payload_mismatch_defect = plm_d;
      status.multiframe_present = MULTIFRAME_PRESENT;
      status.no_crc_interworking_status = fa_state == FA_CRC_NONCRC;
      status.accepted_signal_label = accepted;
      status.payload_mismatch_cause = plm_d && !tsf_s2;
      status.all_ones_cause = ais_d && !plm_d && !tsf_s2
        && ctrl.all_ones_report_enable;
      status.frame_loss_cause = lof_d && !ais_d && !plm_d
        && !tsf_s2;
    end
  end

  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr = PSEL && PENABLE && PREADY && PWRITE;
  assign addr_ok = PADDR == REG_CTRL || PADDR == REG_STATUS;

  // APB answer: ready in the first access cycle, error on unmapped words
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end
    else
    begin
      PREADY <= apb_setup;
      if (apb_setup)
      begin
        PSLVERR <= !addr_ok;
        if (PADDR == REG_CTRL)
          PRDATA <= 32'(ctrl);
        else if (PADDR == REG_STATUS)
          PRDATA <= 32'(status);
        else
          PRDATA <= 32'h0000_0000;
      end
    end
  end

  // Control word; writes land only at the completing access edge
  always_ff @(posedge MCLK)
  begin
    if (RST)
      ctrl <= CTRL_RESET;
    else if (apb_wr && PADDR == REG_CTRL)
      ctrl <= vc12d_ctrl_t'(PWDATA[3:0]);
  end

endmodule : vc12d_sink

// [testbench/vc12d_checker.sv]
// Port-level assertions for the VC-12 demapping sink
// ------
// Checker
// ------
module vc12d_checker (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TRAIL_SIGNAL_FAIL_IN,
  input wire logic SERVER_FAIL_OUT,
  input wire logic TRIBUTARY_DATA_OUT,
  input wire logic MULTIFRAME_PRESENT
);
  timeunit 1ns;
  timeprecision 1ns;
  import vc12d_pkg::*;
  logic [3:0] ctrl;
  logic [5:0] hold;
  logic [3:0] tsf_run;
  logic [1:0] off_run;
  logic tsf_q;
  logic done;
  logic rd_st;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  assign done = PSEL && PENABLE && PREADY;
  assign rd_st = done && !PWRITE && PADDR == REG_STATUS;
  // Shadow control and saturating run counters, so no count wraps
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ctrl <= CTRL_RESET;
      hold <= 6'h0;
      tsf_run <= 4'h0;
      off_run <= 2'h0;
      tsf_q <= 1'b0;
    end
    else
    begin
      if (done && PWRITE && PADDR == REG_CTRL)
        ctrl <= PWDATA[3:0];
      hold <= (SERVER_FAIL_OUT || !ctrl[0]) ? hold + 6'(hold < 6'h3C) : 6'h0;
      tsf_q <= TRAIL_SIGNAL_FAIL_IN;
      tsf_run <= (TRAIL_SIGNAL_FAIL_IN == tsf_q) ?
        tsf_run + 4'(tsf_run < 4'h8) : 4'h0;
      off_run <= (ctrl[3:2] == 2'h0) ? off_run + 2'(off_run < 2'h3) : 2'h0;
    end
  end
  a_bad_addr:
    assert property (done && PADDR != REG_CTRL && PADDR != REG_STATUS
      |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped not refused");
  a_idle_status:
    assert property (rd_st && !ctrl[0] |-> PRDATA == 32'h0)
      else $error("status shown while idle");
  a_ones_insert:
    assert property (hold == 6'h3C && (SERVER_FAIL_OUT || !ctrl[0])
      |-> TRIBUTARY_DATA_OUT) else $error("no all-ones output");
  a_ssf_defects:
    assert property (rd_st && ctrl[0] |-> SERVER_FAIL_OUT == |PRDATA[10:8])
      else $error("server fail off defects");
  a_plm_cause:
    assert property (rd_st && ctrl[0] && tsf_run == 4'h8
      |-> PRDATA[0] == (PRDATA[8] && !tsf_q)) else $error("bad mismatch cause");
  a_ais_cause:
    assert property (rd_st && ctrl[0] && tsf_run == 4'h8 |-> PRDATA[1] ==
      (PRDATA[9] && !PRDATA[8] && !tsf_q && ctrl[1])) else $error("bad ais cause");
  a_lof_cause:
    assert property (rd_st && ctrl[0] && tsf_run == 4'h8 |-> PRDATA[2] ==
      (PRDATA[10] && !PRDATA[9] && !PRDATA[8] && !tsf_q))
      else $error("bad lof cause");
  a_off_no_mfp:
    assert property (off_run == 2'h3 |-> !MULTIFRAME_PRESENT)
      else $error("multiframe present while off");
endmodule : vc12d_checker
bind vc12d_sink vc12d_checker u_chk (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TRAIL_SIGNAL_FAIL_IN(TRAIL_SIGNAL_FAIL_IN),
  .SERVER_FAIL_OUT(SERVER_FAIL_OUT), .TRIBUTARY_DATA_OUT(TRIBUTARY_DATA_OUT),
  .MULTIFRAME_PRESENT(MULTIFRAME_PRESENT));

// [testbench/vc12d_container_src.sv]
// Upstream model: maps a framed 2 Mbit/s stream into gapped containers
module vc12d_container_src (
  input wire logic [2:0] label,
  input wire logic ais,
  output logic ck,
  output logic dat,
  output logic fs
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MF_BITS = 8'hF4;
  int n = 0;
  int cnt = 0;
  int f;
  int p;
  int i;
  logic take;
  logic v;
  // Frame word in even frames, multiframe bit in odd ones
  function automatic logic trib(int k);
    int fr;
    logic [7:0] ts0;
    fr = k / 256 % 16;
    ts0 = fr[0] ? {MF_BITS[fr >> 1], 7'h5F} : 8'h1B;
    return ais || (k % 256 < 8 ? ts0[7 - k % 256] : k[1]);
  endfunction : trib
  // One container per 500 us; justification alternates to keep the rate
  initial
  begin
    ck = 1'b0;
    dat = 1'b0;
    fs = 1'b0;
    #100;
    forever
    begin
      for (int b = 0; b < 1120; b++)
      begin
        f = b / 280;
        p = b / 8 % 35;
        i = b % 8;
        take = 1'b0;
        v = 1'b1;
        if (p == 0)
          v = f == 0 && i > 3 && i < 7 && label[6 - i];
        else if (f > 0 && p == 1 && i < 2)
          v = cnt[0] ^ (f == (cnt + i) % 3 + 1);
        else if (f == 3 && (p == 1 && i == 7 || p == 2 && i == 0))
          take = !cnt[0];
        else
          take = p > 1 && p < 34;
        if (take)
        begin
          v = trib(n);
          n++;
        end
        dat = v;
        fs = b == 0;
        #40 ck = 1'b1;
        #40 ck = 1'b0;
        #(b % 7 < 3 ? 367 : 366);
      end
      cnt++;
    end
  end
endmodule : vc12d_container_src

// [testbench/vc12d_sink_tb_top.sv]
// Self-checking bench for the VC-12 demapping sink
module vc12d_sink_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import vc12d_pkg::*;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h0;
  logic [31:0] PWDATA = 32'h0;
  logic TSF = 1'b0;
  logic [2:0] label = 3'h2;
  logic ais = 1'b0;
  logic ck, dat, fs, dout, sf, mfp, rdy, perr, err, one;
  logic [31:0] prd, rd;
  int n_fail = 0;
  int samples_checked = 0;
  always #5 MCLK = ~MCLK;
  vc12d_container_src u_src (.label(label), .ais(ais), .ck(ck), .dat(dat),
    .fs(fs));
  vc12d_sink #(.MFA_TIMEOUT_CYC(400000)) DUT (.MCLK(MCLK), .RST(RST),
    .CONTAINER_DATA_IN(dat), .CONTAINER_GAPPED_CLOCK_IN(ck),
    .CONTAINER_FRAME_START_IN(fs), .TRAIL_SIGNAL_FAIL_IN(TSF),
    .TRIBUTARY_DATA_OUT(dout), .TRIBUTARY_CLOCK_OUT(), .SERVER_FAIL_OUT(sf),
    .FRAME_START_OUT(), .MULTIFRAME_START_OUT(), .MULTIFRAME_PRESENT(mfp),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(prd), .PREADY(rdy), .PSLVERR(perr));
  // ------
  // Shared tasks
  // ------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for ready rather than assuming a latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    while (rdy !== 1'b1)
      @(posedge MCLK);
    rd = prd;
    err = perr;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task wt(input int c);
    repeat (c) @(posedge MCLK);
  endtask : wt
  // Output stays high for 500 cycles, about ten tributary bits
  task ones;
    one = 1'b1;
    repeat (500)
    begin
      @(posedge MCLK);
      one &= dout;
    end
  endtask : ones
  // ------
  // Scenarios
  // ------
  task t_regs;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'hB);
    apb(1'b1, 8'h08, 32'hF);
    chk(32'(err), 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[8]), 32'h1);
    chk(32'(rd[0]), 32'h1);
    chk(32'(sf), 32'h1);
    TSF <= 1'b1;
    wt(12);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[0]), 32'h0);
    TSF <= 1'b0;
    $display("registers and label done");
  endtask : t_regs
  task t_align;
    wt(400000);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h90);
    chk(32'(mfp), 32'h1);
    ones;
    chk(32'(one), 32'h0);
    apb(1'b1, REG_CTRL, 32'h7);
    chk(32'(mfp), 32'h1);
    apb(1'b1, REG_CTRL, 32'h3);
    wt(10);
    chk(32'(mfp), 32'h0);
    apb(1'b1, REG_CTRL, 32'hB);
    $display("alignment done");
  endtask : t_align
  // All-ones stream in and out again, reporting switched off once in between
  task t_ais;
    ais <= 1'b1;
    wt(60000);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[9]), 32'h1);
    chk(32'(rd[2:1]), 32'h1);
    ones;
    chk(32'(one), 32'h1);
    apb(1'b1, REG_CTRL, 32'h9);
    wt(5);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[1]), 32'h0);
    apb(1'b1, REG_CTRL, 32'hB);
    ais <= 1'b0;
    wt(60000);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[9]), 32'h0);
    chk(32'(sf), 32'h0);
    ones;
    chk(32'(one), 32'h0);
    $display("all-ones done");
  endtask : t_ais
  task t_idle;
    apb(1'b1, REG_CTRL, 32'hA);
    wt(100);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    ones;
    chk(32'(one), 32'h1);
    apb(1'b1, REG_CTRL, 32'hB);
    $display("inactive done");
  endtask : t_idle
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    t_regs;
    t_align;
    t_ais;
    t_idle;
    print_verdict;
  end
  // Watchdog well past the roughly 5.2 ms the scenarios need
  initial
  begin
    #7000000;
    n_fail++;
    print_verdict;
  end
endmodule : vc12d_sink_tb_top
